// *** mcs_consts.svh ***
// Constants for the motor command source select block
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH

// Timing
`define MCS_CLK_NS 4
`define MCS_TICK_NS 100000
`define MCS_BAUD_DEF 9600
`define MCS_GAP_BITS 39

// Serial settings, source select codes and their defaults
`define MCS_PROTO_MODBUS 1'b0
`define MCS_PROTO_ALT 1'b1
`define MCS_PAR_NONE 2'h0
`define MCS_PAR_EVEN 2'h1
`define MCS_PAR_ODD 2'h2
`define MCS_STOP_ONE 1'b0
`define MCS_STOP_TWO 1'b1
`define MCS_WAIT_DEF 14'h0064
`define MCS_WAIT_MAX 14'h2710
`define MCS_SRC_PIN 1'b0
`define MCS_SRC_REG 1'b1

// Register map
`define MCS_ADDR_CMD 16'h001E
`define MCS_ADDR_FCLR 16'h0040
`define MCS_ADDR_PLOAD 16'h0048
`define MCS_ADDR_TRAV 16'h0402
`define MCS_ADDR_SPD 16'h0502
`define MCS_REG_RST 16'h0000

// Command word fields
`define MCS_BIT_EXC 13
`define MCS_BIT_HOME 11
`define MCS_BIT_RVS 10
`define MCS_BIT_FWD 9
`define MCS_BIT_START 8
`define MCS_BIT_STOP 6
`define MCS_DATA_MSB 5

// Frame handling
`define MCS_FC_READ 8'h03
`define MCS_FC_WR1 8'h06
`define MCS_FC_WRN 8'h10
`define MCS_EXC_FLAG 8'h80
`define MCS_EXC_FUNC 8'h01
`define MCS_EXC_DATA 8'h03
`define MCS_BCAST 8'h00
`define MCS_MAX_REGS 16'h000A
`define MCS_BUF_DEPTH 32
`define MCS_CRC_INIT 16'hFFFF
`define MCS_CRC_POLY 16'hA001

`endif

// *** mcs_pkg.sv ***
// Types shared by the motor command source select block
package mcs_pkg;

    typedef enum logic [2:0] {
        ST_RECV,
        ST_CHECK,
        ST_EXEC,
        ST_WAIT,
        ST_SEND
    } mcs_state_e;

    typedef struct packed {
        logic excite;
        logic start;
        logic [5:0] data_no;
        logic home;
        logic forward_run_request;
        logic reverse_run_request;
        logic stop;
        logic fault_clear;
        logic pos_load;
    } mcs_motion_s;

endpackage

// *** mcs_top.sv ***
// Modbus RTU slave with command register and source select for start, excitation, data number and home/forward/reverse
`include "mcs_consts.svh"

module mcs_top
    import mcs_pkg::*;
#(
    parameter int unsigned P_BIT_CYCLES =
        1000000000 / (`MCS_BAUD_DEF * `MCS_CLK_NS),
    parameter int unsigned P_TICK_CYCLES = `MCS_TICK_NS / `MCS_CLK_NS
) (
    // Clock, reset, enable
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_CLK_EN,
    // Settings
    input wire logic [7:0] I_SLAVE_ADDR,
    input wire logic I_PROTOCOL,
    input wire logic [1:0] I_PARITY,
    input wire logic I_STOP_BITS,
    input wire logic [13:0] I_WAIT_TIME,
    input wire logic I_START_SRC,
    input wire logic I_EXC_SRC,
    input wire logic I_DATA_SRC,
    input wire logic I_HFR_SRC,
    input wire logic I_PIN_STOP_EN,
    // Control pins
    input wire logic I_START_PIN,
    input wire logic I_WINDING_RELEASE_PIN,
    input wire logic I_STOP_PIN,
    input wire logic [5:0] I_OP_DATA_SELECT_LINES,
    input wire logic I_HOME_PIN,
    input wire logic I_FORWARD_RUN_REQUEST,
    input wire logic I_REVERSE_RUN_REQUEST,
    input wire logic I_FAULT_CLEAR_PIN,
    input wire logic I_POSITION_LOAD_PIN,
    // RS-485 line
    input wire logic I_RXD,
    output logic O_TXD,
    output logic O_TX_OE,
    // Motion commands
    output logic O_EXCITE,
    output logic O_START,
    output logic [5:0] O_DATA_NO,
    output logic O_HOME,
    output logic O_FWD,
    output logic O_RVS,
    output logic O_STOP,
    output logic O_FAULT_CLEAR,
    output logic O_POSITION_LOAD,
    output logic [31:0] O_TRAVEL_AMOUNT,
    output logic [31:0] O_RUN_SPEED
);

    localparam logic [23:0] BIT_M1 = 24'(P_BIT_CYCLES - 1);
    localparam logic [23:0] BIT_HALF = 24'(P_BIT_CYCLES / 2);
    localparam logic [23:0] GAP_LIM = 24'(P_BIT_CYCLES * `MCS_GAP_BITS);
    localparam logic [23:0] TICK_M1 = 24'(P_TICK_CYCLES - 1);
    localparam logic [5:0] DEPTH = 6'(`MCS_BUF_DEPTH);

    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MCS_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic par_bit(input logic [7:0] b,
                                     input logic [1:0] m);
        return (m == `MCS_PAR_ODD) ? ~(^b) : (^b);
    endfunction

    // Link state
    mcs_state_e st_q, st_d;
    logic rx_prev_q, rx_busy_q, rx_busy_d;
    logic [23:0] rx_cyc_q, rx_cyc_d, gap_q, gap_d;
    logic [3:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic [5:0] nb_q, nb_d;
    logic [15:0] crc_q, crc_d;
    logic bad_q, bad_d, noreply_q, noreply_d;
    logic [7:0] fc_q, fc_d, exc_q, exc_d;
    logic [15:0] base_q, base_d;
    logic [4:0] cnt_q, cnt_d, idx_q, idx_d, len_q, len_d;
    logic [23:0] tick_q, tick_d;
    logic [13:0] wt_q, wt_d;
    logic [11:0] tx_sh_q, tx_sh_d;
    logic [3:0] tx_bit_q, tx_bit_d;
    logic [23:0] tx_cyc_q, tx_cyc_d;
    logic [5:0] tx_i_q, tx_i_d;
    logic [15:0] tx_crc_q, tx_crc_d;
    logic txd_q, txd_d, oe_q, oe_d;
    logic [7:0] fb_q [0:`MCS_BUF_DEPTH-1];
    logic buf_we;
    logic [4:0] buf_wa, dix, lim;
    logic [7:0] buf_wd, tx_byte;
    logic par_en;
    logic [3:0] nbits;
    logic [13:0] wait_lim;
    logic [15:0] nregs;
    // Register access between link and register file
    logic wr_en;
    logic [15:0] wr_addr, wr_data, rd_addr, rd_data;

    assign par_en = (I_PARITY != `MCS_PAR_NONE);
    assign nbits = 4'd10 + {3'h0, par_en} + {3'h0, I_STOP_BITS};
    assign wait_lim = (I_WAIT_TIME > `MCS_WAIT_MAX) ? `MCS_WAIT_MAX
                                                    : I_WAIT_TIME;
    assign nregs = {fb_q[4], fb_q[5]};
    assign dix = ((fc_q == `MCS_FC_WR1) ? 5'h04 : 5'h07)
                 + {idx_q[3:0], 1'b0};
    assign lim = (fc_q == `MCS_FC_READ) ? {cnt_q[3:0], 1'b0} : cnt_q;

    always_comb begin
        tx_byte = fb_q[tx_i_q[4:0]];
        if (tx_i_q == {1'b0, len_q}) begin
            tx_byte = tx_crc_q[7:0];
        end else if (tx_i_q == {1'b0, len_q} + 6'h01) begin
            tx_byte = tx_crc_q[15:8];
        end else if (exc_q != 8'h00 && tx_i_q == 6'h01) begin
            tx_byte = fc_q | `MCS_EXC_FLAG;
        end else if (exc_q != 8'h00 && tx_i_q == 6'h02) begin
            tx_byte = exc_q;
        end else if (fc_q == `MCS_FC_READ && tx_i_q == 6'h02) begin
            tx_byte = {3'h0, cnt_q[3:0], 1'b0};
        end
    end

    always_comb begin
        st_d = st_q;
        rx_busy_d = rx_busy_q;
        rx_cyc_d = rx_cyc_q;
        gap_d = gap_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        nb_d = nb_q;
        crc_d = crc_q;
        bad_d = bad_q;
        noreply_d = noreply_q;
        fc_d = fc_q;
        exc_d = exc_q;
        base_d = base_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        len_d = len_q;
        tick_d = tick_q;
        wt_d = wt_q;
        tx_sh_d = tx_sh_q;
        tx_bit_d = tx_bit_q;
        tx_cyc_d = tx_cyc_q;
        tx_i_d = tx_i_q;
        tx_crc_d = tx_crc_q;
        txd_d = txd_q;
        oe_d = oe_q;
        buf_we = 1'b0;
        buf_wa = nb_q[4:0];
        buf_wd = rx_sh_q;
        wr_en = 1'b0;
        wr_addr = base_q + {11'h000, idx_q};
        wr_data = {fb_q[dix], fb_q[dix + 5'h01]};
        rd_addr = base_q + {12'h000, idx_q[4:1]};
        case (st_q)
            ST_RECV: begin
                if (!rx_busy_q) begin
                    if (gap_q != GAP_LIM) begin
                        gap_d = gap_q + 24'h00_0001;
                    end
                    if (rx_prev_q && !I_RXD) begin
                        rx_busy_d = 1'b1;
                        rx_cyc_d = BIT_HALF;
                        rx_bit_d = 4'h0;
                        gap_d = 24'h00_0000;
                    end else if (gap_q == GAP_LIM && nb_q != 6'h00) begin
                        st_d = ST_CHECK;
                    end
                end else begin
                    gap_d = 24'h00_0000;
                    if (rx_cyc_q != 24'h00_0000) begin
                        rx_cyc_d = rx_cyc_q - 24'h00_0001;
                    end else begin
                        rx_cyc_d = BIT_M1;
                        rx_bit_d = rx_bit_q + 4'h1;
                        if (rx_bit_q == 4'h0) begin
                            // A glitch that is gone by mid start bit
                            rx_busy_d = !I_RXD;
                        end else if (rx_bit_q <= 4'h8) begin
                            rx_sh_d = {I_RXD, rx_sh_q[7:1]};
                        end else if (rx_bit_q == 4'h9 && par_en) begin
                            if (I_RXD != par_bit(rx_sh_q, I_PARITY)) begin
                                bad_d = 1'b1;
                            end
                        end else begin
                            rx_busy_d = 1'b0;
                            if (!I_RXD || nb_q == DEPTH) begin
                                bad_d = 1'b1;
                            end else begin
                                buf_we = 1'b1;
                                nb_d = nb_q + 6'h01;
                                crc_d = crc_byte(crc_q, rx_sh_q);
                            end
                        end
                    end
                end
            end
            ST_CHECK: begin
                st_d = ST_EXEC;
                nb_d = 6'h00;
                crc_d = `MCS_CRC_INIT;
                bad_d = 1'b0;
                idx_d = 5'h00;
                exc_d = 8'h00;
                fc_d = fb_q[1];
                base_d = {fb_q[2], fb_q[3]};
                noreply_d = (fb_q[0] == `MCS_BCAST);
                len_d = 5'h06;
                cnt_d = nregs[4:0];
                if (bad_q || crc_q != 16'h0000 || nb_q < 6'h04
                    || I_PROTOCOL != `MCS_PROTO_MODBUS
                    || (fb_q[0] != I_SLAVE_ADDR
                        && fb_q[0] != `MCS_BCAST)) begin
                    st_d = ST_RECV;
                end else if (fb_q[1] == `MCS_FC_WR1) begin
                    cnt_d = 5'h01;
                    if (nb_q != 6'h08) begin
                        exc_d = `MCS_EXC_DATA;
                    end
                end else if (fb_q[1] == `MCS_FC_WRN) begin
                    if (nregs == 16'h0000 || nregs > `MCS_MAX_REGS
                        || fb_q[6] != {nregs[6:0], 1'b0}
                        || nb_q != 6'h09 + {nregs[4:0], 1'b0}) begin
                        exc_d = `MCS_EXC_DATA;
                    end
                end else if (fb_q[1] == `MCS_FC_READ) begin
                    len_d = 5'h03 + {nregs[3:0], 1'b0};
                    if (nregs == 16'h0000 || nregs > `MCS_MAX_REGS
                        || nb_q != 6'h08) begin
                        exc_d = `MCS_EXC_DATA;
                    end
                end else begin
                    exc_d = `MCS_EXC_FUNC;
                end
            end
            ST_EXEC: begin
                if (exc_q != 8'h00 || idx_q == lim) begin
                    st_d = noreply_q ? ST_RECV : ST_WAIT;
                    len_d = (exc_q != 8'h00) ? 5'h03 : len_q;
                    tick_d = 24'h00_0000;
                    wt_d = 14'h0000;
                end else begin
                    idx_d = idx_q + 5'h01;
                    if (fc_q == `MCS_FC_READ) begin
                        buf_we = 1'b1;
                        buf_wa = 5'h03 + idx_q;
                        buf_wd = idx_q[0] ? rd_data[7:0] : rd_data[15:8];
                    end else begin
                        wr_en = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (wt_q >= wait_lim) begin
                    st_d = ST_SEND;
                    tx_i_d = 6'h00;
                    tx_bit_d = 4'h0;
                    tx_cyc_d = 24'h00_0000;
                    tx_crc_d = `MCS_CRC_INIT;
                end else if (tick_q == TICK_M1) begin
                    tick_d = 24'h00_0000;
                    wt_d = wt_q + 14'h0001;
                end else begin
                    tick_d = tick_q + 24'h00_0001;
                end
            end
            ST_SEND: begin
                if (tx_cyc_q != 24'h00_0000) begin
                    tx_cyc_d = tx_cyc_q - 24'h00_0001;
                end else if (tx_bit_q != 4'h0) begin
                    txd_d = tx_sh_q[0];
                    tx_sh_d = {1'b1, tx_sh_q[11:1]};
                    tx_bit_d = tx_bit_q - 4'h1;
                    tx_cyc_d = BIT_M1;
                end else if (tx_i_q == {1'b0, len_q} + 6'h02) begin
                    st_d = ST_RECV;
                    oe_d = 1'b0;
                    txd_d = 1'b1;
                end else begin
                    oe_d = 1'b1;
                    tx_sh_d = {2'b11, par_en ? par_bit(tx_byte, I_PARITY)
                                             : 1'b1, tx_byte, 1'b0};
                    tx_bit_d = nbits;
                    tx_i_d = tx_i_q + 6'h01;
                    if (tx_i_q < {1'b0, len_q}) begin
                        tx_crc_d = crc_byte(tx_crc_q, tx_byte);
                    end
                end
            end
            default: st_d = ST_RECV;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_q <= ST_RECV;
            rx_prev_q <= 1'b1;
            rx_busy_q <= 1'b0;
            rx_cyc_q <= 24'h00_0000;
            gap_q <= 24'h00_0000;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            nb_q <= 6'h00;
            crc_q <= `MCS_CRC_INIT;
            bad_q <= 1'b0;
            noreply_q <= 1'b0;
            fc_q <= 8'h00;
            exc_q <= 8'h00;
            base_q <= 16'h0000;
            cnt_q <= 5'h00;
            idx_q <= 5'h00;
            len_q <= 5'h00;
            tick_q <= 24'h00_0000;
            wt_q <= 14'h0000;
            tx_sh_q <= 12'hFFF;
            tx_bit_q <= 4'h0;
            tx_cyc_q <= 24'h00_0000;
            tx_i_q <= 6'h00;
            tx_crc_q <= `MCS_CRC_INIT;
            txd_q <= 1'b1;
            oe_q <= 1'b0;
        end else if (I_CLK_EN) begin
            st_q <= st_d;
            rx_prev_q <= I_RXD;
            rx_busy_q <= rx_busy_d;
            rx_cyc_q <= rx_cyc_d;
            gap_q <= gap_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            nb_q <= nb_d;
            crc_q <= crc_d;
            bad_q <= bad_d;
            noreply_q <= noreply_d;
            fc_q <= fc_d;
            exc_q <= exc_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            len_q <= len_d;
            tick_q <= tick_d;
            wt_q <= wt_d;
            tx_sh_q <= tx_sh_d;
            tx_bit_q <= tx_bit_d;
            tx_cyc_q <= tx_cyc_d;
            tx_i_q <= tx_i_d;
            tx_crc_q <= tx_crc_d;
            txd_q <= txd_d;
            oe_q <= oe_d;
        end
    end

    // Frame buffer has no reset: only bytes written this frame are read
    always_ff @(posedge I_SYS_CLK) begin
        if (I_CLK_EN && buf_we) begin
            fb_q[buf_wa] <= buf_wd;
        end
    end

    // Register file and source selection
    logic [15:0] cmd_q, cmd_d, fclr_q, fclr_d, pload_q, pload_d;
    logic [31:0] trav_q, trav_d, spd_q, spd_d;
    mcs_motion_s mot_q, mot_d;
    logic start_lvl, fclr_lvl, pload_lvl;
    logic start_prev_q, fclr_prev_q, pload_prev_q;

    always_comb begin
        cmd_d = cmd_q;
        fclr_d = fclr_q;
        pload_d = pload_q;
        trav_d = trav_q;
        spd_d = spd_q;
        if (wr_en) begin
            if (wr_addr == `MCS_ADDR_CMD) begin
                cmd_d = wr_data;
            end else if (wr_addr == `MCS_ADDR_FCLR) begin
                fclr_d = wr_data;
            end else if (wr_addr == `MCS_ADDR_PLOAD) begin
                pload_d = wr_data;
            end else if (wr_addr == `MCS_ADDR_TRAV) begin
                trav_d[31:16] = wr_data;
            end else if (wr_addr == `MCS_ADDR_TRAV + 16'h0001) begin
                trav_d[15:0] = wr_data;
            end else if (wr_addr == `MCS_ADDR_SPD) begin
                spd_d[31:16] = wr_data;
            end else if (wr_addr == `MCS_ADDR_SPD + 16'h0001) begin
                spd_d[15:0] = wr_data;
            end
        end
        rd_data = 16'h0000;
        if (rd_addr == `MCS_ADDR_CMD) begin
            rd_data = cmd_q;
        end else if (rd_addr == `MCS_ADDR_FCLR) begin
            rd_data = fclr_q;
        end else if (rd_addr == `MCS_ADDR_PLOAD) begin
            rd_data = pload_q;
        end else if (rd_addr == `MCS_ADDR_TRAV) begin
            rd_data = trav_q[31:16];
        end else if (rd_addr == `MCS_ADDR_TRAV + 16'h0001) begin
            rd_data = trav_q[15:0];
        end else if (rd_addr == `MCS_ADDR_SPD) begin
            rd_data = spd_q[31:16];
        end else if (rd_addr == `MCS_ADDR_SPD + 16'h0001) begin
            rd_data = spd_q[15:0];
        end
        // Each selector below is its own input, except I_HFR_SRC, which home, forward and reverse share
        start_lvl = I_START_SRC ? cmd_q[`MCS_BIT_START]
                                : I_START_PIN;
        fclr_lvl = I_FAULT_CLEAR_PIN | fclr_q[0];
        pload_lvl = I_POSITION_LOAD_PIN | pload_q[0];
        mot_d.start = start_lvl && !start_prev_q;
        mot_d.excite = I_EXC_SRC ? cmd_q[`MCS_BIT_EXC]
                                 : !I_WINDING_RELEASE_PIN;
        mot_d.data_no = I_DATA_SRC ? cmd_q[`MCS_DATA_MSB:0]
                                   : I_OP_DATA_SELECT_LINES;
        mot_d.home = I_HFR_SRC ? cmd_q[`MCS_BIT_HOME] : I_HOME_PIN;
        mot_d.forward_run_request = I_HFR_SRC ? cmd_q[`MCS_BIT_FWD]
                              : I_FORWARD_RUN_REQUEST;
        mot_d.reverse_run_request = I_HFR_SRC ? cmd_q[`MCS_BIT_RVS]
                              : I_REVERSE_RUN_REQUEST;
        mot_d.stop = cmd_q[`MCS_BIT_STOP]
                     | (I_PIN_STOP_EN & I_STOP_PIN);
        mot_d.fault_clear = fclr_lvl && !fclr_prev_q;
        mot_d.pos_load = pload_lvl && !pload_prev_q;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cmd_q <= `MCS_REG_RST;
            fclr_q <= `MCS_REG_RST;
            pload_q <= `MCS_REG_RST;
            trav_q <= {`MCS_REG_RST, `MCS_REG_RST};
            spd_q <= {`MCS_REG_RST, `MCS_REG_RST};
            mot_q <= '0;
            start_prev_q <= 1'b0;
            fclr_prev_q <= 1'b0;
            pload_prev_q <= 1'b0;
        end else if (I_CLK_EN) begin
            cmd_q <= cmd_d;
            fclr_q <= fclr_d;
            pload_q <= pload_d;
            trav_q <= trav_d;
            spd_q <= spd_d;
            mot_q <= mot_d;
            start_prev_q <= start_lvl;
            fclr_prev_q <= fclr_lvl;
            pload_prev_q <= pload_lvl;
        end
    end

    assign O_TXD = txd_q;
    assign O_TX_OE = oe_q;
    assign O_EXCITE = mot_q.excite;
    assign O_START = mot_q.start;
    assign O_DATA_NO = mot_q.data_no;
    assign O_HOME = mot_q.home;
    assign O_FWD = mot_q.forward_run_request;
    assign O_RVS = mot_q.reverse_run_request;
    assign O_STOP = mot_q.stop;
    assign O_FAULT_CLEAR = mot_q.fault_clear;
    assign O_POSITION_LOAD = mot_q.pos_load;
    assign O_TRAVEL_AMOUNT = trav_q;
    assign O_RUN_SPEED = spd_q;

endmodule

// *** mcs_master.sv ***
// Modbus master model that drives the slave's receive line
module mcs_master (
    input wire logic i_clk,
    input wire logic i_txd,
    input wire logic i_oe,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BT = 8;
    logic [7:0] rx_q[$];
    logic [7:0] sent[$];
    initial o_line = 1'b1;
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // A flipped check bit is sent only where a test wants a refusal
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [15:0] c;
        logic [10:0] w;
        c = crc(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        sent = f;
        rx_q = {};
        foreach (f[i]) begin
            w = {1'b1, ^f[i], f[i], 1'b0};
            for (int b = 0; b < 11; b++) begin
                o_line <= w[b];
                repeat (BT) @(posedge i_clk);
            end
        end
    endtask
    // Parity is skipped so a low parity bit is not taken for a start
    always begin
        logic [7:0] d;
        @(negedge i_txd iff i_oe);
        repeat (BT + BT / 2) @(posedge i_clk);
        for (int b = 0; b < 8; b++) begin
            d[b] = i_txd;
            repeat (BT) @(posedge i_clk);
        end
        rx_q.push_back(d);
        repeat (BT) @(posedge i_clk);
    end
endmodule

// *** mcs_top_assertions.sv ***
// Checker for the command outputs of the top module
`include "mcs_consts.svh"
module mcs_top_assertions (
    input wire logic I_SYS_CLK, I_NRST, I_START_SRC, I_EXC_SRC,
    input wire logic I_DATA_SRC, I_HFR_SRC, I_PIN_STOP_EN, I_START_PIN,
    input wire logic I_WINDING_RELEASE_PIN, I_STOP_PIN,
    input wire logic I_FORWARD_RUN_REQUEST, I_FAULT_CLEAR_PIN,
    input wire logic [5:0] I_OP_DATA_SELECT_LINES, O_DATA_NO,
    input wire logic O_START, O_EXCITE, O_STOP, O_FWD,
    input wire logic O_FAULT_CLEAR, O_TXD, O_TX_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_NRST);
    sequence one_pulse;
        O_START ##1 !O_START;
    endsequence
    sequence tx_lead;
        O_TXD ##1 !O_TXD;
    endsequence
    start_width_a: assert property ($rose(O_START) |-> one_pulse)
        else $error("start pulse too long");
    start_pin_a: assert property (I_START_SRC == `MCS_SRC_PIN
        && $rose(I_START_PIN) |-> ##[1:3] O_START) else $error("no start");
    // The edge that releases reset still loads zeros, so it is not judged
    excite_pin_a: assert property (I_NRST &&
        I_EXC_SRC == `MCS_SRC_PIN |=>
        O_EXCITE == !$past(I_WINDING_RELEASE_PIN)) else $error("excite");
    stop_pin_a: assert property (I_PIN_STOP_EN && I_STOP_PIN |=>
        O_STOP) else $error("pin stop ignored");
    data_pin_a: assert property (I_NRST &&
        I_DATA_SRC == `MCS_SRC_PIN |=>
        O_DATA_NO == $past(I_OP_DATA_SELECT_LINES)) else $error("data no");
    fwd_pin_a: assert property (I_NRST &&
        I_HFR_SRC == `MCS_SRC_PIN |=>
        O_FWD == $past(I_FORWARD_RUN_REQUEST)) else $error("forward");
    clear_pin_a: assert property ($rose(I_FAULT_CLEAR_PIN) |->
        ##[1:3] O_FAULT_CLEAR) else $error("fault clear missing");
    tx_start_a: assert property ($rose(O_TX_OE) |-> tx_lead)
        else $error("reply start bit late");
endmodule
bind mcs_top mcs_top_assertions u_chk (.*);

// *** motor_command_source_select_bench.sv ***
// Self-checking bench for the command source select block
`include "mcs_consts.svh"
module motor_command_source_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_SYS_CLK, I_NRST, I_CLK_EN, I_PROTOCOL, I_STOP_BITS, I_RXD;
    logic [7:0] I_SLAVE_ADDR;
    logic [1:0] I_PARITY;
    logic [13:0] I_WAIT_TIME;
    logic I_START_SRC, I_EXC_SRC, I_DATA_SRC, I_HFR_SRC, I_PIN_STOP_EN;
    logic I_START_PIN, I_WINDING_RELEASE_PIN, I_STOP_PIN, I_HOME_PIN;
    logic [5:0] I_OP_DATA_SELECT_LINES, O_DATA_NO;
    logic I_FORWARD_RUN_REQUEST, I_REVERSE_RUN_REQUEST, O_TXD, O_TX_OE;
    logic I_FAULT_CLEAR_PIN, I_POSITION_LOAD_PIN, O_EXCITE, O_START;
    logic O_HOME, O_FWD, O_RVS, O_STOP, O_FAULT_CLEAR, O_POSITION_LOAD;
    logic [31:0] O_TRAVEL_AMOUNT, O_RUN_SPEED;
    int error_cnt, checks, starts, pulses, cyc;
    // Expected home, forward, reverse, stop after each command word
    localparam logic [19:0] CMD [5] = '{20'h2_2014, 20'h2_0010,
        20'h2_8008, 20'h2_4002, 20'h2_0401};
    mcs_top #(.P_BIT_CYCLES(8), .P_TICK_CYCLES(4)) DUT (.*);
    mcs_master M (.i_clk(I_SYS_CLK), .i_txd(O_TXD), .i_oe(O_TX_OE),
        .o_line(I_RXD));
    initial begin
        I_SYS_CLK = 1'b0;
        forever #2 I_SYS_CLK = ~I_SYS_CLK;
    end
    always @(posedge I_SYS_CLK) begin
        starts <= starts + int'(O_START === 1'b1);
        pulses <= pulses + int'(O_FAULT_CLEAR === 1'b1)
            + int'(O_POSITION_LOAD === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge I_SYS_CLK);
    endtask
    task automatic xfer(input logic [7:0] f[$]);
        M.send(f, 1'b0);
        for (int i = 0; i < 4000 && M.rx_q.size() < 8; i++) tick(1);
        tick(40);
        chk(32'(M.rx_q.size()), 32'h0000_0008);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        xfer({8'h01, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]});
        foreach (M.sent[i]) chk(32'(M.rx_q[i]), 32'(M.sent[i]));
    endtask
    task automatic wr32(input logic [15:0] a, input logic [31:0] v);
        xfer({8'h01, 8'h10, a[15:8], a[7:0], 8'h00, 8'h02, 8'h04,
            v[31:24], v[23:16], v[15:8], v[7:0]});
    endtask
    initial begin
        {I_NRST, I_PROTOCOL, I_STOP_BITS, I_START_SRC, I_EXC_SRC,
            I_DATA_SRC, I_HFR_SRC, I_PIN_STOP_EN} = 8'h00;
        {I_START_PIN, I_FAULT_CLEAR_PIN, I_POSITION_LOAD_PIN, I_STOP_PIN,
            I_WINDING_RELEASE_PIN, I_HOME_PIN, I_FORWARD_RUN_REQUEST,
            I_REVERSE_RUN_REQUEST, I_OP_DATA_SELECT_LINES} = 14'h0000;
        I_CLK_EN = 1'b1;
        I_SLAVE_ADDR = 8'h01;
        I_PARITY = `MCS_PAR_EVEN;
        I_WAIT_TIME = 14'h0002;
        tick(16);
        chk(32'({O_TXD, O_TX_OE, O_EXCITE, O_STOP}), 32'h0000_0008);
        I_NRST <= 1'b1;
        tick(4);
        {I_START_PIN, I_FAULT_CLEAR_PIN, I_POSITION_LOAD_PIN, I_PIN_STOP_EN,
            I_STOP_PIN, I_HOME_PIN, I_FORWARD_RUN_REQUEST,
            I_REVERSE_RUN_REQUEST, I_OP_DATA_SELECT_LINES} <= 14'h3fea;
        tick(4);
        chk(32'({O_EXCITE, O_HOME, O_FWD, O_RVS, O_STOP, O_DATA_NO}),
            32'h0000_07ea);
        chk(32'(starts), 32'h0000_0001);
        chk(32'(pulses), 32'h0000_0002);
        {I_PIN_STOP_EN, I_FORWARD_RUN_REQUEST, I_FAULT_CLEAR_PIN,
            I_POSITION_LOAD_PIN} <= 4'h0;
        tick(4);
        chk(32'(O_STOP), 32'h0000_0000);
        // Release pin high: excitation must now follow the register only
        {I_START_SRC, I_EXC_SRC, I_DATA_SRC, I_HFR_SRC,
            I_WINDING_RELEASE_PIN} <= 5'h1f;
        tick(4);
        wr(`MCS_ADDR_CMD, 16'h2000);
        chk(32'({M.rx_q[6], M.rx_q[7]}), 32'h0000_f00c);
        chk(32'(O_EXCITE), 32'h0000_0001);
        wr32(`MCS_ADDR_TRAV, 32'h0000_03e8);
        wr32(`MCS_ADDR_SPD, 32'h0000_1388);
        chk(O_TRAVEL_AMOUNT, 32'h0000_03e8);
        chk(O_RUN_SPEED, 32'h0000_1388);
        wr(`MCS_ADDR_CMD, 16'h2101);
        wr(`MCS_ADDR_CMD, 16'h2001);
        chk(32'(starts), 32'h0000_0002);
        chk(32'(O_DATA_NO), 32'h0000_0001);
        wr(`MCS_ADDR_FCLR, 16'h0001);
        chk(32'(pulses), 32'h0000_0003);
        wr(`MCS_ADDR_PLOAD, 16'h0001);
        chk(32'(pulses), 32'h0000_0004);
        foreach (CMD[i]) begin
            wr(`MCS_ADDR_CMD, CMD[i][19:4]);
            chk(32'({O_HOME, O_FWD, O_RVS, O_STOP}),
                32'(CMD[i][3:0]));
        end
        for (int k = 0; k < 3; k++) begin
            I_SLAVE_ADDR <= (k == 1) ? 8'h02 : 8'h01;
            I_PROTOCOL <= 1'(k == 2);
            tick(1);
            M.send({8'h01, 8'h06, 8'h00, 8'h1e, 8'h00, 8'h00},
                1'(k == 0));
            tick(3000);
            chk(32'(M.rx_q.size()), 32'h0000_0000);
            chk(32'(O_EXCITE), 32'h0000_0001);
        end
        end_of_test();
    end
endmodule
